// ==== design/rth_pkg.sv ====
/*
 Constants for the reset, thermal-trip and suspend-exit holdoff controller:
 register map, field positions, reset values and cycle counts.
 Assumes a 40 MHz always-on clock.
*/
package rth_pkg;
    localparam int CLK_MHZ        = 40;
    localparam int CLK_PERIOD_NS  = 25;
    localparam int CNT_W          = 20;
    // Request debounce and reset hold times
    localparam int DEBOUNCE_US    = 16000;
    localparam int HOLD_MIN_US    = 5000;
    localparam int HOLD_MAX_US    = 6000;
    localparam int DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
    localparam int HOLD_CYC       = HOLD_MIN_US * CLK_MHZ;
    // Overheat trip response and glitch filter
    localparam int TRIP_RESP_NS   = 1000;
    localparam int TRIP_RESP_CYC  = TRIP_RESP_NS / CLK_PERIOD_NS;
    localparam int GLITCH_NS      = 25;
    localparam int GLITCH_CYC     = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] TRIP_FILTER = 2'(GLITCH_CYC);
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RSTCTL = 8'h08;
    localparam logic [7:0] OFS_LEGWO  = 8'h0c;
    localparam logic [7:0] OFS_LEGRO  = 8'h10;
    // Control fields
    localparam int CTRL_DEBOUNCE  = 0;
    localparam int CTRL_TVP       = 1;
    localparam int CTRL_HOLDOFF   = 2;
    localparam int CTRL_ALT       = 3;
    localparam int CTRL_ESPI      = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam int RSTCTL_FULL    = 3;
    localparam logic [7:0] RSTCTL_RST = 8'h00;
    // Status fields
    localparam int ST_PTS         = 0;
    localparam int ST_PBTN        = 1;
    localparam int ST_RST_BUSY    = 2;
    localparam int ST_TRIPPED     = 3;
    localparam int ST_FLASH_BLK   = 4;
    localparam int ST_TMR_FAST    = 5;
    localparam int ST_WINDOW      = 6;
    localparam int ST_PIN_LEVEL   = 7;
    localparam logic [15:0] LEGWO_RST = 16'h0000;
    localparam logic [7:0]  LEGRO_RST = 8'h00;
endpackage

// ==== design/rth_reset_thermal_holdoff_ctl.sv ====
/*
 Host reset request, overheat trip shutdown, suspend-exit holdoff and
 alternate access mode logic with an APB register slave.
 Assumes all pin inputs synchronous to I_CLK; power state inputs come
 from the surrounding power sequencer.
*/
`timescale 1ns/1ps
// Contract
// - Reset request detected on falling edge, or after 16 ms debounce.
// - Resulting reset held 5 to 6 ms whatever the request input does.
// - No new reset until request seen inactive and full S0 with platform reset off.
// - Reset control port bit 3 turns the reset into a full power cycle.
// - Reset request only acts while core power good is high.
// - Overheat trip forces S5: sleep outputs low, prior trip status set.
// - Sleep outputs low within 1 us of trip sampled active.
// - Trip low glitches under 25 ns never cause shutdown.
// - Trip monitoring starts at platform reset release or processor power good.
// - Trip monitoring stops when processor power good falls.
// - Trip event clears power button status.
// - After S4/S5 entry with flash sleep asserted, holdoff delays resume.
// - Holdoff ignored outside S4/S5 entry with flash sleep asserted.
// - No flash access while flash sleep asserted or holdoff still asserted.
// - Holdoff pin is a plain input until firmware enables its function.
// - With eSPI, no flash sharing, but holdoff still delays resume.
// - Alternate mode reads write-only and restores read-only legacy registers.
// - Alternate mode around timer reads leaves timer fast until restored.
module rth_reset_thermal_holdoff_ctl
    import rth_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int HOLD_CYCLES     = HOLD_CYC
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RESET,
    input  wire logic        i_PSEL,
    input  wire logic        i_PENABLE,
    input  wire logic        i_PWRITE,
    input  wire logic [7:0]  i_PADDR,
    input  wire logic [31:0] i_PWDATA,
    input  wire logic        i_HOST_RESET_REQUEST_N,
    input  wire logic        i_CORE_POWER_GOOD,
    input  wire logic        i_PLATFORM_RESET_OUT_N,
    input  wire logic        i_SYSTEM_IN_S0,
    input  wire logic        i_OVERHEAT_TRIP_N,
    input  wire logic        i_PROCESSOR_POWER_GOOD,
    input  wire logic        i_POWER_BUTTON_PRESS,
    input  wire logic        i_SLEEP_S3_REQ_N,
    input  wire logic        i_SLEEP_S4_REQ_N,
    input  wire logic        i_SLEEP_S5_REQ_N,
    input  wire logic        i_S4S5_ENTRY,
    input  wire logic        i_FLASH_DOMAIN_SLEEP_N,
    input  wire logic        i_SUSPEND_EXIT_HOLDOFF_N,
    output logic             o_PREADY,
    output logic             o_PSLVERR,
    output logic [31:0]      o_PRDATA,
    output logic             o_HOST_RESET,
    output logic             o_GLOBAL_RESET,
    output logic             o_SLEEP_S3_OUT_N,
    output logic             o_SLEEP_S4_OUT_N,
    output logic             o_SLEEP_S5_OUT_N,
    output logic             o_RESUME_HOLD,
    output logic             o_FLASH_ACCESS_EN,
    output logic             o_LEGACY_TIMER_FAST
);
    typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_REARM} rth_rst_state_t;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    rth_rst_state_t st_reg, st_next;
    logic [CNT_W-1:0] deb_cnt_reg, deb_cnt_next, hold_cnt_reg, hold_cnt_next;
    logic deb_level_reg, deb_level_next, full_reg, full_next;
    logic [1:0] trip_cnt_reg, trip_cnt_next;
    logic monitor_reg, monitor_next, ppg_reg, prst_reg;
    logic tripped_reg, tripped_next, pts_reg, pts_next, pb_reg, pb_next;
    logic window_reg, window_next, alt_read_reg, alt_read_next;
    logic fast_reg, fast_next;
    logic [4:0]  ctrl_reg, ctrl_next;
    logic [7:0]  rstctl_reg, rstctl_next, legro_reg, legro_next;
    logic [15:0] legwo_reg, legwo_next;
    logic [31:0] rdata_next;
    logic ready_next, err_next;
    logic req_fall, trip_event, hold, flash_blk, start_evt, done, setup, mapped;
    logic [7:0] status;

    assign setup = i_PSEL && i_PENABLE && !o_PREADY;
    assign done  = i_PSEL && i_PENABLE && o_PREADY;
    assign mapped = hit(i_PADDR, OFS_CTRL) || hit(i_PADDR, OFS_STATUS) || hit(i_PADDR, OFS_RSTCTL)
                 || hit(i_PADDR, OFS_LEGWO) || hit(i_PADDR, OFS_LEGRO);
    assign status = {i_SUSPEND_EXIT_HOLDOFF_N, window_reg, fast_reg, flash_blk,
                     tripped_reg, st_reg != ST_IDLE, pb_reg, pts_reg};

    // Request debounce, both directions alike
    always_comb begin
        deb_level_next = deb_level_reg;
        deb_cnt_next   = '0;
        if (!ctrl_reg[CTRL_DEBOUNCE]) begin
            deb_level_next = i_HOST_RESET_REQUEST_N;
        end else if (i_HOST_RESET_REQUEST_N != deb_level_reg) begin
            if (deb_cnt_reg == CNT_W'(DEBOUNCE_CYCLES - 1)) begin
                deb_level_next = i_HOST_RESET_REQUEST_N;
            end else begin
                deb_cnt_next = deb_cnt_reg + 1'b1;
            end
        end
    end
    assign req_fall = deb_level_reg && !deb_level_next;

    // Reset sequence; request pin lives in the primary well so gate with core power
    always_comb begin
        st_next       = st_reg;
        hold_cnt_next = '0;
        full_next     = full_reg;
        unique case (st_reg)
            ST_IDLE: begin
                if (req_fall && i_CORE_POWER_GOOD) begin
                    st_next   = ST_HOLD;
                    full_next = rstctl_reg[RSTCTL_FULL];
                end
            end
            ST_HOLD: begin
                hold_cnt_next = hold_cnt_reg + 1'b1;
                if (hold_cnt_reg == CNT_W'(HOLD_CYCLES - 1)) begin
                    st_next = ST_REARM;
                end
            end
            ST_REARM: begin
                if (deb_level_reg && i_SYSTEM_IN_S0 && i_PLATFORM_RESET_OUT_N) begin
                    st_next = ST_IDLE;
                end
            end
        endcase
    end

    // Trip window, filter and shutdown
    always_comb begin
        start_evt    = ctrl_reg[CTRL_TVP] ? (i_PROCESSOR_POWER_GOOD && !ppg_reg)
                                          : (i_PLATFORM_RESET_OUT_N && !prst_reg);
        monitor_next = !i_PROCESSOR_POWER_GOOD ? 1'b0 : (monitor_reg || start_evt);
        trip_cnt_next = i_OVERHEAT_TRIP_N ? 2'h0
                      : (trip_cnt_reg == TRIP_FILTER ? trip_cnt_reg : trip_cnt_reg + 2'h1);
        // One clean low sample is not enough: a sub-period glitch can still hit one edge
        trip_event   = monitor_reg && !i_OVERHEAT_TRIP_N && trip_cnt_reg == TRIP_FILTER;
        // A trip in the same cycle as a power-good drop still wins
        tripped_next = trip_event || (tripped_reg && i_CORE_POWER_GOOD);
    end

    // Suspend-exit holdoff and flash gating
    always_comb begin
        window_next = window_reg;
        if (!ctrl_reg[CTRL_HOLDOFF]) begin
            window_next = 1'b0;
        end else if (i_S4S5_ENTRY && !i_FLASH_DOMAIN_SLEEP_N) begin
            window_next = 1'b1;
        end else if (i_FLASH_DOMAIN_SLEEP_N && i_SUSPEND_EXIT_HOLDOFF_N) begin
            window_next = 1'b0;
        end
        hold      = window_reg && !i_SUSPEND_EXIT_HOLDOFF_N;
        flash_blk = !i_FLASH_DOMAIN_SLEEP_N || (hold && !ctrl_reg[CTRL_ESPI]);
    end

    // Register file, status flags and alternate access mode
    always_comb begin
        ctrl_next     = ctrl_reg;
        rstctl_next   = rstctl_reg;
        legwo_next    = legwo_reg;
        legro_next    = legro_reg;
        pts_next      = pts_reg;
        pb_next       = pb_reg;
        alt_read_next = alt_read_reg;
        fast_next     = fast_reg;
        if (done && i_PWRITE) begin
            if (hit(i_PADDR, OFS_CTRL)) ctrl_next = i_PWDATA[4:0];
            if (hit(i_PADDR, OFS_RSTCTL)) rstctl_next = i_PWDATA[7:0];
            if (hit(i_PADDR, OFS_STATUS)) begin
                pts_next = pts_reg && !i_PWDATA[ST_PTS];
                pb_next  = pb_reg && !i_PWDATA[ST_PBTN];
            end
            if (hit(i_PADDR, OFS_LEGWO)) begin
                legwo_next = i_PWDATA[15:0];
                fast_next  = 1'b0;
            end
            // Read-only legacy value is restorable only in alternate mode
            if (hit(i_PADDR, OFS_LEGRO) && ctrl_reg[CTRL_ALT]) legro_next = i_PWDATA[7:0];
        end
        if (done && !i_PWRITE && hit(i_PADDR, OFS_LEGWO) && ctrl_reg[CTRL_ALT]) begin
            alt_read_next = 1'b1;
        end
        if (ctrl_reg[CTRL_ALT] && !ctrl_next[CTRL_ALT]) begin
            fast_next     = fast_next || alt_read_next;
            alt_read_next = 1'b0;
        end
        if (i_POWER_BUTTON_PRESS) pb_next = 1'b1;
        if (trip_event) begin
            pts_next = 1'b1;
            pb_next  = 1'b0;
        end
    end

    // APB: one wait cycle so read data leaves a flop
    always_comb begin
        ready_next = setup;
        err_next   = setup && !mapped;
        rdata_next = '0;
        if (setup && !i_PWRITE) begin
            if (hit(i_PADDR, OFS_CTRL)) rdata_next = {27'h0, ctrl_reg};
            if (hit(i_PADDR, OFS_STATUS)) rdata_next = {24'h0, status};
            if (hit(i_PADDR, OFS_RSTCTL)) rdata_next = {24'h0, rstctl_reg};
            if (hit(i_PADDR, OFS_LEGWO) && ctrl_reg[CTRL_ALT]) rdata_next = {16'h0, legwo_reg};
            if (hit(i_PADDR, OFS_LEGRO)) rdata_next = {24'h0, legro_reg};
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            st_reg              <= ST_IDLE;
            deb_cnt_reg         <= '0;
            hold_cnt_reg        <= '0;
            deb_level_reg       <= 1'b1;
            full_reg            <= 1'b0;
            trip_cnt_reg        <= 2'h0;
            monitor_reg         <= 1'b0;
            ppg_reg             <= 1'b0;
            prst_reg            <= 1'b0;
            tripped_reg         <= 1'b0;
            pts_reg             <= 1'b0;
            pb_reg              <= 1'b0;
            window_reg          <= 1'b0;
            alt_read_reg        <= 1'b0;
            fast_reg            <= 1'b0;
            ctrl_reg            <= CTRL_RST;
            rstctl_reg          <= RSTCTL_RST;
            legwo_reg           <= LEGWO_RST;
            legro_reg           <= LEGRO_RST;
            o_PREADY            <= 1'b0;
            o_PSLVERR           <= 1'b0;
            o_PRDATA            <= '0;
            o_HOST_RESET        <= 1'b0;
            o_GLOBAL_RESET      <= 1'b0;
            o_SLEEP_S3_OUT_N    <= 1'b1;
            o_SLEEP_S4_OUT_N    <= 1'b1;
            o_SLEEP_S5_OUT_N    <= 1'b1;
            o_RESUME_HOLD       <= 1'b0;
            o_FLASH_ACCESS_EN   <= 1'b0;
            o_LEGACY_TIMER_FAST <= 1'b0;
        end else begin
            st_reg              <= st_next;
            deb_cnt_reg         <= deb_cnt_next;
            hold_cnt_reg        <= hold_cnt_next;
            deb_level_reg       <= deb_level_next;
            full_reg            <= full_next;
            trip_cnt_reg        <= trip_cnt_next;
            monitor_reg         <= monitor_next;
            ppg_reg             <= i_PROCESSOR_POWER_GOOD;
            prst_reg            <= i_PLATFORM_RESET_OUT_N;
            tripped_reg         <= tripped_next;
            pts_reg             <= pts_next;
            pb_reg              <= pb_next;
            window_reg          <= window_next;
            alt_read_reg        <= alt_read_next;
            fast_reg            <= fast_next;
            ctrl_reg            <= ctrl_next;
            rstctl_reg          <= rstctl_next;
            legwo_reg           <= legwo_next;
            legro_reg           <= legro_next;
            o_PREADY            <= ready_next;
            o_PSLVERR           <= err_next;
            o_PRDATA            <= rdata_next;
            o_HOST_RESET        <= st_next == ST_HOLD && !full_next;
            o_GLOBAL_RESET      <= st_next == ST_HOLD && full_next;
            // Trip bypasses the normal power-down handshakes entirely
            o_SLEEP_S3_OUT_N    <= i_SLEEP_S3_REQ_N && !tripped_next;
            o_SLEEP_S4_OUT_N    <= i_SLEEP_S4_REQ_N && !tripped_next;
            o_SLEEP_S5_OUT_N    <= i_SLEEP_S5_REQ_N && !tripped_next;
            o_RESUME_HOLD       <= hold;
            o_FLASH_ACCESS_EN   <= !flash_blk;
            o_LEGACY_TIMER_FAST <= fast_next;
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    property p_hold_len;
        (st_reg == ST_HOLD) |-> hold_cnt_reg < CNT_W'(HOLD_CYCLES);
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("reset hold overran");

    property p_trip_fast;
        trip_event |=> !o_SLEEP_S3_OUT_N && !o_SLEEP_S4_OUT_N && !o_SLEEP_S5_OUT_N;
    endproperty
    a_trip_fast: assert property (p_trip_fast) else $error("sleep outputs late after trip");

    property p_glitch;
        trip_event |-> !i_OVERHEAT_TRIP_N && $past(!i_OVERHEAT_TRIP_N);
    endproperty
    a_glitch: assert property (p_glitch) else $error("trip taken from a single sample");

    property p_mon_stop;
        !i_PROCESSOR_POWER_GOOD |=> !monitor_reg ##0 !trip_event;
    endproperty
    a_mon_stop: assert property (p_mon_stop) else $error("trip monitored without power good");

    property p_core_gate;
        (st_reg == ST_IDLE && !i_CORE_POWER_GOOD) |=> st_reg == ST_IDLE;
    endproperty
    a_core_gate: assert property (p_core_gate) else $error("reset started without core power");

    property p_kind;
        (st_reg == ST_HOLD) |=> (o_GLOBAL_RESET == full_reg) || st_reg == ST_REARM;
    endproperty
    a_kind: assert property (p_kind) else $error("wrong reset kind");

    property p_rearm;
        (st_reg == ST_REARM && !(deb_level_reg && i_SYSTEM_IN_S0 && i_PLATFORM_RESET_OUT_N))
            |=> st_reg == ST_REARM;
    endproperty
    a_rearm: assert property (p_rearm) else $error("re-armed too early");

    property p_trip_sts;
        trip_event |=> pts_reg && !pb_reg;
    endproperty
    a_trip_sts: assert property (p_trip_sts) else $error("trip status bits wrong");

    property p_flash;
        !i_FLASH_DOMAIN_SLEEP_N |=> !o_FLASH_ACCESS_EN;
    endproperty
    a_flash: assert property (p_flash) else $error("flash enabled while asleep");

    property p_ignore;
        !window_reg |=> !o_RESUME_HOLD;
    endproperty
    a_ignore: assert property (p_ignore) else $error("holdoff honoured outside window");

    property p_fast;
        (ctrl_reg[CTRL_ALT] && alt_read_reg ##1 !ctrl_reg[CTRL_ALT]) |-> o_LEGACY_TIMER_FAST;
    endproperty
    a_fast: assert property (p_fast) else $error("timer rate flag missed");
endmodule // rth_reset_thermal_holdoff_ctl

// ==== verification/rth_ec_model.sv ====
/*
 Behavioural embedded controller driving the suspend-exit holdoff pin.
 Assumes the testbench tells it when the host has reached S0 once.
*/
`timescale 1ns/1ps
module rth_ec_model #(
    parameter int HOLD_LEN  = 30,
    parameter int WATCH_LEN = 4
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_flash_sleep_n,
    input  wire logic i_seen_s0,
    input  wire logic i_flash_active,
    output logic      o_holdoff_n
);
    logic prev_reg, armed_reg;
    int   cnt_reg;
    // HOLD_LEN stands for the flash watch window plus the controller's own flash use
    always @(posedge i_clk) begin
        prev_reg <= i_flash_sleep_n;
        if (i_reset) begin
            o_holdoff_n <= 1'b1;
            cnt_reg     <= 0;
            armed_reg   <= 1'b0;
        end else if (prev_reg && !i_flash_sleep_n && armed_reg) begin
            o_holdoff_n <= 1'b0;
            cnt_reg     <= HOLD_LEN;
        end else if (cnt_reg > HOLD_LEN - WATCH_LEN && i_flash_active) begin
            // Host flash use inside the watch window means a global reset: back off until S0
            o_holdoff_n <= 1'b1;
            cnt_reg     <= 0;
            armed_reg   <= 1'b0;
        end else begin
            armed_reg <= armed_reg || i_seen_s0;
            if (cnt_reg > 0) begin
                cnt_reg <= cnt_reg - 1;
                if (cnt_reg == 1)
                    o_holdoff_n <= 1'b1;
            end
        end
    end
endmodule // rth_ec_model

// ==== verification/tb.sv ====
/*
 Self-checking testbench for the reset, trip and holdoff controller.
 Assumes short debounce and hold parameters; APB master in the bench.
*/
`timescale 1ns/1ps
module tb;
    import rth_pkg::*;
    localparam int HOLD = 10;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, req_n = 1, cpg = 1, plt_n = 0;
    logic trip_n = 1, ppg = 1, pbtn = 0, s4s5 = 0, fsl_n = 1, seen_s0 = 0, s0 = 1;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, host_rst, glob_rst, s3_n, s4_n, s5_n, rhold, flash_en, tfast, hold_n, er;
    int n_fail = 0, n_tests = 0;
    always #12.5 clk = ~clk;
    rth_reset_thermal_holdoff_ctl #(.DEBOUNCE_CYCLES(8), .HOLD_CYCLES(HOLD)) u_dut (
        .I_CLK(clk), .I_RESET(rst), .i_PSEL(psel), .i_PENABLE(pen), .i_PWRITE(pwr),
        .i_PADDR(paddr), .i_PWDATA(pwdata), .i_HOST_RESET_REQUEST_N(req_n),
        .i_CORE_POWER_GOOD(cpg), .i_PLATFORM_RESET_OUT_N(plt_n), .i_SYSTEM_IN_S0(s0),
        .i_OVERHEAT_TRIP_N(trip_n), .i_PROCESSOR_POWER_GOOD(ppg), .i_POWER_BUTTON_PRESS(pbtn),
        .i_SLEEP_S3_REQ_N(1'b1), .i_SLEEP_S4_REQ_N(1'b1), .i_SLEEP_S5_REQ_N(1'b1),
        .i_S4S5_ENTRY(s4s5), .i_FLASH_DOMAIN_SLEEP_N(fsl_n), .i_SUSPEND_EXIT_HOLDOFF_N(hold_n),
        .o_PREADY(pready), .o_PSLVERR(pslverr), .o_PRDATA(prdata), .o_HOST_RESET(host_rst),
        .o_GLOBAL_RESET(glob_rst), .o_SLEEP_S3_OUT_N(s3_n), .o_SLEEP_S4_OUT_N(s4_n),
        .o_SLEEP_S5_OUT_N(s5_n), .o_RESUME_HOLD(rhold), .o_FLASH_ACCESS_EN(flash_en),
        .o_LEGACY_TIMER_FAST(tfast));
    rth_ec_model u_ec (.i_clk(clk), .i_reset(rst), .i_flash_sleep_n(fsl_n), .i_seen_s0(seen_s0),
        .i_flash_active(flash_en), .o_holdoff_n(hold_n));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        // Only the watchdog ends a wait for the answer
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 0; pen <= 0;
    endtask
    task automatic t_reset(input logic [31:0] ctl, input logic [31:0] rc, input logic pg,
                           input int len, input int eh, input int eg);
        int nh, ng;
        nh = 0; ng = 0;
        apb(1, OFS_CTRL, ctl);
        apb(1, OFS_RSTCTL, rc);
        cpg <= pg; req_n <= 0;
        for (int k = 0; k < 45; k++) begin
            @(posedge clk);
            nh += int'(host_rst === 1'b1);
            ng += int'(glob_rst === 1'b1);
            if (k == len) req_n <= 1;
        end
        chk("host reset cycles", eh, nh);
        chk("global reset cycles", eg, ng);
        cpg <= 1;
        repeat (12) @(posedge clk);
    endtask
    task automatic t_rearm();
        int nh;
        nh = 0;
        s0 <= 0;
        req_n <= 0;
        for (int k = 0; k < 60; k++) begin
            @(posedge clk);
            nh += int'(host_rst === 1'b1);
            if (k == 2 || k == 30) req_n <= 1;
            if (k == 20 || k == 45) req_n <= 0;
            if (k == 40) s0 <= 1;
        end
        chk("host reset rearm", 2 * HOLD, nh);
        req_n <= 1;
        repeat (12) @(posedge clk);
    endtask
    task automatic t_trip(input int len, input logic pg, input logic ex);
        int first;
        first = -1;
        @(posedge clk);
        pbtn <= 1; ppg <= pg; plt_n <= 0;
        @(posedge clk);
        pbtn <= 0; plt_n <= 1;
        repeat (3) @(posedge clk);
        trip_n <= 0;
        for (int k = 0; k < 41; k++) begin
            @(posedge clk);
            if (k == len - 1) trip_n <= 1;
            if (first < 0 && {s3_n, s4_n, s5_n} === 3'b000) first = k;
        end
        chk("trip within 1 us", ex, first >= 0 && first <= 40);
        apb(0, OFS_STATUS, 32'h0);
        chk("trip status", ex ? 32'h1 : 32'h2, rd & 32'h3);
        // Dropping core power good is the only way out of a trip shutdown
        cpg <= 0; ppg <= 1;
        @(posedge clk);
        cpg <= 1;
        repeat (2) @(posedge clk);
        chk("sleep outs restored", 32'h7, {s3_n, s4_n, s5_n});
    endtask
    task automatic t_tvp(input logic [31:0] ctl, input logic ex);
        apb(1, OFS_CTRL, ctl);
        ppg <= 0;
        plt_n <= 1;
        repeat (2) @(posedge clk);
        ppg <= 1;
        repeat (2) @(posedge clk);
        trip_n <= 0;
        repeat (4) @(posedge clk);
        chk("trip valid point", ex, {s3_n, s4_n, s5_n} === 3'b000);
        trip_n <= 1;
        cpg <= 0;
        @(posedge clk);
        cpg <= 1;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_hold(input logic [31:0] ctl, input logic s);
        logic e;
        int n;
        e = ctl[CTRL_HOLDOFF] & s;
        n = 0;
        apb(1, OFS_CTRL, ctl);
        s4s5 <= s; fsl_n <= 0;
        repeat (5) @(posedge clk);
        fsl_n <= 1; s4s5 <= 0;
        repeat (3) @(posedge clk);
        chk("resume hold", e, rhold);
        chk("flash enable", !(e && !ctl[CTRL_ESPI]), flash_en);
        while (rhold !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
        chk("flash enable after holdoff", 1, flash_en);
        repeat (40) @(posedge clk);
    endtask
    task automatic t_regs();
        apb(0, 8'h20, 32'h0);
        chk("unmapped error", 1, er);
        chk("unmapped data", 0, rd);
        apb(1, OFS_LEGWO, 32'h1234);
        apb(0, OFS_LEGWO, 32'h0);
        chk("write-only hidden", 0, rd);
        chk("mapped error", 0, er);
        apb(1, OFS_CTRL, 32'h8);
        apb(0, OFS_LEGWO, 32'h0);
        chk("write-only readable", 32'h1234, rd);
        apb(1, OFS_LEGRO, 32'h5a);
        apb(1, OFS_CTRL, 32'h0);
        apb(1, OFS_LEGRO, 32'h33);
        apb(0, OFS_LEGRO, 32'h0);
        chk("read-only restored", 32'h5a, rd);
        repeat (2) @(posedge clk);
        chk("timer fast", 1, tfast);
        apb(1, OFS_LEGWO, 32'h1234);
        repeat (2) @(posedge clk);
        chk("timer restored", 0, tfast);
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #(25 * 30000);
        n_fail++;
        give_verdict();
    end
    initial begin
        // Reset stands for the resume reset the controller keeps low until done with flash
        repeat (4) @(posedge clk);
        rst <= 0; plt_n <= 1; seen_s0 <= 1;
        t_reset(0, 0, 1, 15, HOLD, 0);
        t_rearm();
        t_reset(0, 8, 1, 15, 0, HOLD);
        t_reset(0, 0, 0, 15, 0, 0);
        t_reset(1, 0, 1, 4, 0, 0);
        t_reset(1, 0, 1, 20, HOLD, 0);
        t_trip(1, 1, 0);
        t_trip(4, 0, 0);
        t_trip(2, 1, 1);
        t_tvp(0, 0);
        t_tvp(32'h2, 1);
        t_hold(0, 1);
        t_hold(4, 0);
        t_hold(4, 1);
        t_hold(32'h14, 1);
        t_regs();
        give_verdict();
    end
endmodule // tb
